// file: rtl/calibration_ram_fault_classify.v
/*
  Classifies a protection fault on a calibration_ram access into a data
  storage or machine check exception; a plain core fault without relocation
  raises neither. Assumes same-clock inputs.
*/
`timescale 1ns/100ps
module calibration_ram_fault_classify (
  input  wire core_clk,
  input  wire rstn,
  input  wire faultValid,
  input  wire fromCore,
  input  wire overlayAccess,
  input  wire dataRelocationBit,
  output reg  dataStorageExc,
  output reg  machineCheckExc
);

  wire coreNormal;

  // only plain core accesses take the data storage path
  assign coreNormal = fromCore & ~overlayAccess;

  // registered one-cycle exception pulses
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dataStorageExc  <= 1'b0;
      machineCheckExc <= 1'b0;
    end else begin
      dataStorageExc  <= faultValid & coreNormal & dataRelocationBit;
      // slave-mode and overlay faults escalate; a plain core fault without relocation is dropped
      machineCheckExc <= faultValid & ~coreNormal;
    end
  end

endmodule // calibration_ram_fault_classify

// file: rtl/internal_memory_map_decode.v
/*
  Internal memory block address decoder: places the 4-Mbyte block at one
  of eight bases, selects a section, checks calibration_ram protection and
  classifies faults, and times burst_buffer_unit register accesses.
  Assumes a single-cycle request strobe from one bus master at a time and
  a location setting driven by the system_interface_unit on this clock.
*/
`timescale 1ns/100ps
`include "mem_decode_consts.vh"
module internal_memory_map_decode (
  input  wire                      core_clk,
  input  wire                      rstn,
  input  wire [2:0]                regionLocation,
  input  wire                      reqValid,
  input  wire [31:0]               reqAddr,
  input  wire                      reqWrite,
  input  wire                      reqFromCore,
  input  wire                      reqOverlay,
  input  wire                      dataRelocationBit,
  input  wire [7:0]                calramWriteProtect,
  output reg                       selValid,
  output reg  [2:0]                selTarget,
  output reg  [21:0]               selOffset,
  output reg                       selExternal,
  output wire                      sprDone,
  output wire                      dataStorageExc,
  output wire                      machineCheckExc
);

  ////////////////////////////////////////////////////////////////////////
  // layout inside the block, offsets from the selected base:
  //   000000..07FFFF  first flash module
  //   080000..0FFFFF  second flash module
  //   100000..2F9FFF  reserved, passed to the external bus
  //   2FA000..2FBFFF  burst buffer unit registers
  //   2FC000..2FFFFF  interface unit and flash control
  //   300000..307FFF  intermodule bus peripherals
  //   308000..37FFFF  reserved
  //   380000..383FFF  local bus control registers
  //   384000..3F6FFF  reserved
  //   3F7000..3FFFFF  calibration RAM, small module then large one
  // the map is fixed; only the base moves, so a second chip on the same
  // bus simply picks another of the eight bases

  ////////////////////////////////////////////////////////////////////////
  // decode

  // address bit positions of the base select and the must-be-zero top
  localparam BASE_LO = `REGION_OFS_W;
  localparam BASE_HI = `REGION_OFS_W + `REGION_SEL_W - 1;
  localparam TOP_LO  = `REGION_OFS_W + `REGION_SEL_W;

  // true when offset lies in [lo,hi]; used for every section window
  function inWin;
    input [21:0] ofs;
    input [21:0] lo;
    input [21:0] hi;
    begin
      inWin = (ofs >= lo) && (ofs <= hi);
    end
  endfunction

  // section lookup for an offset already known to lie in the region; the
  // windows never overlap, so the order of the tests is free
  function [`TGT_W-1:0] sectionOf;
    input [21:0] o;
    begin
      if (inWin(o, `FLASH_A_LO, `FLASH_A_HI))
        sectionOf = `TGT_FLASH_A;
      else if (inWin(o, `FLASH_B_LO, `FLASH_B_HI))
        sectionOf = `TGT_FLASH_B;
      else if (inWin(o, `SPR_LO, `SPR_HI))
        sectionOf = `TGT_SPR;
      else if (inWin(o, `CTRL_LO, `CTRL_HI))
        sectionOf = `TGT_CTRL;
      else if (inWin(o, `IMB_LO, `IMB_HI))
        sectionOf = `TGT_IMB;
      else if (inWin(o, `LBUS_CTRL_LO, `LBUS_CTRL_HI))
        sectionOf = `TGT_LBUS_CTRL;
      else if (inWin(o, `CALIBRATION_RAM_B_LO, `CALIBRATION_RAM_A_HI))
        sectionOf = `TGT_CALIBRATION_RAM;
      else
        sectionOf = `TGT_EXTERNAL;  // reserved holes fall through to the bus
    end
  endfunction

  wire [21:0] ofs;
  wire        inRegion;
  reg  [2:0]  target;
  wire        isCalram;
  wire [2:0]  protBlk;
  wire        protFault;

  assign ofs = reqAddr[`REGION_OFS_W-1:0];
  // whole block moves as one; the three base bits compare and the top seven bits must be zero
  assign inRegion = (reqAddr[31:TOP_LO] == `REGION_TOP_ZERO) &&
                    (reqAddr[BASE_HI:BASE_LO] == regionLocation);

  // section select; offset is passed on unchanged so each peripheral sees
  // its window from the lowest address upward
  always @* begin
    target = `TGT_EXTERNAL;
    if (inRegion)
      target = sectionOf(ofs);
  end

  // calibration RAM protection: one write-protect bit per 8-Kbyte block
  assign isCalram  = (target == `TGT_CALIBRATION_RAM);
  assign protBlk   = ofs[`PROT_BLK_SHIFT+`PROT_BLK_W-1:`PROT_BLK_SHIFT];
  assign protFault = reqValid & isCalram & reqWrite & calramWriteProtect[protBlk];

  ////////////////////////////////////////////////////////////////////////
  // registered select outputs

  reg selValid_next;
  reg selExternal_next;

  // claim decision; a faulting access is never forwarded to the array,
  // and an outside address is handed to the external bus untouched
  always @* begin
    selValid_next    = 1'b0;
    selExternal_next = 1'b0;
    if (reqValid) begin
      if (target == `TGT_EXTERNAL)
        selExternal_next = 1'b1;
      else if (!protFault)
        selValid_next    = 1'b1;
    end
  end

  // select flops; target and offset follow every cycle, qualified by selValid
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      selValid    <= 1'b0;
      selTarget   <= `TGT_EXTERNAL;
      selOffset   <= 22'h000000;
      selExternal <= 1'b0;
    end else begin
      selValid    <= selValid_next;
      selTarget   <= target;
      selOffset   <= ofs;
      selExternal <= selExternal_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // burst buffer register access timing

  // the first cycle takes the request, the second answers; a request that
  // arrives while busy is ignored, so the master keeps them three apart
  localparam SPR_IDLE = 2'b00;
  localparam SPR_WAIT = 2'b01;
  localparam SPR_DONE = 2'b10;

  reg [1:0] sprState_reg;
  reg [1:0] sprState_next;

  // next-state decode; only core requests are timed here
  always @* begin
    sprState_next = sprState_reg;
    case (sprState_reg)
      SPR_IDLE: begin
        if (reqValid && reqFromCore && target == `TGT_SPR)
          sprState_next = SPR_WAIT;
      end
      SPR_WAIT: begin
        sprState_next = SPR_DONE;
      end
      SPR_DONE: begin
        sprState_next = SPR_IDLE;
      end
      default: begin
        sprState_next = SPR_IDLE;  // unused code recovers at once
      end
    endcase
  end

  // state register
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      sprState_reg <= SPR_IDLE;
    else
      sprState_reg <= sprState_next;
  end

  // done on the second cycle after the request was taken
  assign sprDone = (sprState_reg == SPR_DONE);

  ////////////////////////////////////////////////////////////////////////
  // fault classification

  // exceptions come one cycle after the request, in step with the selects;
  // the classifier sees the raw master attributes of the same cycle
  calibration_ram_fault_classify faultClass (
    .core_clk          (core_clk),
    .rstn              (rstn),
    .faultValid        (protFault),
    .fromCore          (reqFromCore),
    .overlayAccess     (reqOverlay),
    .dataRelocationBit (dataRelocationBit),
    .dataStorageExc    (dataStorageExc),
    .machineCheckExc   (machineCheckExc)
  );

endmodule // internal_memory_map_decode

// file: rtl/mem_decode_consts.vh
/*
  Constants for the internal memory block decoder: region size and base
  selection, section offsets within the 4-Mbyte block, and target codes.
  Assumes byte addresses on a 32-bit bus.
*/
`ifndef MEM_DECODE_CONSTS_VH
`define MEM_DECODE_CONSTS_VH

// region placement
`define REGION_SEL_W      3
`define REGION_OFS_W      22
`define REGION_TOP_ZERO   7'h00

// section bounds, offsets within the block
`define FLASH_A_LO        22'h000000
`define FLASH_A_HI        22'h07FFFF
`define FLASH_B_LO        22'h080000
`define FLASH_B_HI        22'h0FFFFF
`define CTRL_LO           22'h2FC000
`define CTRL_HI           22'h2FFFFF
`define IMB_LO            22'h300000
`define IMB_HI            22'h307FFF
`define LBUS_CTRL_LO      22'h380000
`define LBUS_CTRL_HI      22'h383FFF
`define CALIBRATION_RAM_B_LO       22'h3F7000
`define CALIBRATION_RAM_B_HI       22'h3F7FFF
`define CALIBRATION_RAM_A_LO       22'h3F8000
`define CALIBRATION_RAM_A_HI       22'h3FFFFF
`define SPR_LO            22'h2FA000
`define SPR_HI            22'h2FBFFF

// protection granularity: 8-Kbyte blocks
`define PROT_BLK_SHIFT    13
`define PROT_BLK_W        3
`define PROT_BLK_N        8

// target codes
`define TGT_W             3
`define TGT_EXTERNAL      3'h0
`define TGT_FLASH_A       3'h1
`define TGT_FLASH_B       3'h2
`define TGT_CALIBRATION_RAM        3'h3
`define TGT_CTRL          3'h4
`define TGT_IMB           3'h5
`define TGT_LBUS_CTRL     3'h6
`define TGT_SPR           3'h7

// burst buffer register access latency
`define SPR_CYCLES        2'h2

`endif

// file: test/bus_master_model.sv
/* bus master stand-in: turns a one-cycle go into a request
   assumes go and cmd change on the rising edge */
`timescale 1ns/100ps
module bus_master_model (
  input  logic        core_clk,
  input  logic        go,
  input  logic [34:0] cmd,
  input  logic [2:0]  loc,
  output logic        reqValid,
  output logic [31:0] reqAddr,
  output logic        reqWrite,
  output logic        reqFromCore,
  output logic        reqOverlay,
  output logic [2:0]  regionLocation
);
  initial {reqValid, reqAddr, reqWrite, reqFromCore, reqOverlay, regionLocation} = '0;
  // released lines invert so a stale value never passes for a request
  always @(posedge core_clk) begin
    reqValid <= go;
    {reqAddr, reqWrite, reqFromCore, reqOverlay} <= go ? cmd
      : ~{reqAddr, reqWrite, reqFromCore, reqOverlay};
    regionLocation <= loc;
  end
endmodule // bus_master_model

// file: test/mem_decode_assertions.sv
/* checker for the block decoder: claims, faults, timing
   assumes one-cycle reqValid and core SPECIAL_PURPOSE_REGISTER requests >=3 apart */
`timescale 1ns/100ps
`include "mem_decode_consts.vh"
module mem_decode_assertions (
  input logic        core_clk,
  input logic        rstn,
  input logic [2:0]  regionLocation,
  input logic        reqValid,
  input logic [31:0] reqAddr,
  input logic        reqWrite,
  input logic        reqFromCore,
  input logic        reqOverlay,
  input logic        dataRelocationBit,
  input logic [7:0]  calramWriteProtect,
  input logic        selValid,
  input logic [2:0]  selTarget,
  input logic [21:0] selOffset,
  input logic        selExternal,
  input logic        sprDone,
  input logic        dataStorageExc,
  input logic        machineCheckExc
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // request decode helpers
  wire [21:0] ofs  = reqAddr[21:0];
  wire        inReg = reqValid && reqAddr[31:22] == {7'h00, regionLocation};
  wire        calW = inReg && reqWrite && ofs >= `CALIBRATION_RAM_B_LO;
  sequence sFault; calW && calramWriteProtect[ofs[15:13]]; endsequence
  ////////////////////////////////////////////////////////////////////////
  a_ext_pass: assert property (reqValid && !inReg |=> selExternal && !selValid)
    else $error("outside address not passed on");
  a_flash_lo: assert property (inReg && ofs <= `FLASH_A_HI |=> selTarget == `TGT_FLASH_A)
    else $error("low flash module not selected");
  a_flash_hi: assert property (inReg && ofs[21:19] == 3'h1 |=> selValid && selTarget == 3'h2)
    else $error("high flash module not selected");
  a_offset_pass: assert property (inReg && ofs <= `FLASH_B_HI |=> selOffset == $past(ofs))
    else $error("offset not carried");
  a_dse_core: assert property (sFault ##0 reqFromCore && !reqOverlay && dataRelocationBit
    |=> dataStorageExc && !selValid) else $error("data storage missing");
  a_mce_other: assert property (sFault ##0 (reqOverlay || !reqFromCore)
    |=> machineCheckExc && !dataStorageExc) else $error("machine check missing");
  a_dse_gate: assert property (sFault ##0 !dataRelocationBit |=> !dataStorageExc && !selValid)
    else $error("data storage without relocation");
  a_prot_free: assert property (calW && !calramWriteProtect[ofs[15:13]] |=> selValid)
    else $error("unprotected block refused");
  a_spr_two: assert property (inReg && reqFromCore && ofs >= `SPR_LO && ofs <= `SPR_HI
    |=> !sprDone ##1 sprDone) else $error("register access not two cycles");
endmodule // mem_decode_assertions
bind internal_memory_map_decode mem_decode_assertions chk (.*);

// file: test/test_internal_memory_map_decode.sv
/* self-checking bench: fault classes, corner offsets, random traffic
   assumes the decoder header is on the include path */
`timescale 1ns/100ps
`include "mem_decode_consts.vh"
module test_internal_memory_map_decode;
  logic core_clk = 1'b0, rstn = 1'b0, go = 1'b0, dataRelocationBit = 1'b0;
  logic [34:0] cmd = '0;
  logic [2:0] loc = 3'h0, selTarget, regionLocation, fl, lc;
  logic [7:0] calramWriteProtect = 8'h00, e;
  logic [21:0] selOffset, off;
  logic [31:0] reqAddr;
  logic [9:0] hi;
  logic reqValid, reqWrite, reqFromCore, reqOverlay, selValid, selExternal;
  logic sprDone, dataStorageExc, machineCheckExc;
  logic [21:0] corner [8] = '{22'h07FFFF, 22'h080000, 22'h0FFFFF, 22'h2FA000,
                              22'h2FC000, 22'h300000, 22'h380000, 22'h3FFFFF};
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  initial forever #10 core_clk = ~core_clk;
  bus_master_model master (.*);
  internal_memory_map_decode DUT (.*);
  ////////////////////////////////////////////////////////////////////////
  // reference decode, {claim, external, dse, mce, 1'b0, target}
  function automatic logic [7:0] predict(logic [34:0] c);
    logic [21:0] f = c[24:3];
    logic [2:0] t;
    t = f <= `FLASH_A_HI ? `TGT_FLASH_A : f <= `FLASH_B_HI ? `TGT_FLASH_B
      : f >= `SPR_LO && f <= `SPR_HI ? `TGT_SPR : f >= `CTRL_LO && f <= `CTRL_HI ? `TGT_CTRL
      : f >= `IMB_LO && f <= `IMB_HI ? `TGT_IMB
      : f >= `LBUS_CTRL_LO && f <= `LBUS_CTRL_HI ? `TGT_LBUS_CTRL
      : f >= `CALIBRATION_RAM_B_LO ? `TGT_CALIBRATION_RAM : `TGT_EXTERNAL;
    if (c[34:25] != {7'h00, loc} || t == `TGT_EXTERNAL) return 8'h40;
    if (t == `TGT_CALIBRATION_RAM && c[2] && calramWriteProtect[f[15:13]])
      return (c[0] || !c[1]) ? 8'h10 : {2'h0, dataRelocationBit, 5'h0};
    return {5'h10, t};
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one request through the master, then its answers one and two cycles on
  task automatic access(logic [34:0] c);
    @(posedge core_clk);
    go <= 1'b1;
    cmd <= c;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    #1 e = predict(c);
    check("selValid", selValid, e[7]);
    check("selExternal", selExternal, e[6]);
    check("dataStorageExc", dataStorageExc, e[5]);
    check("machineCheckExc", machineCheckExc, e[4]);
    if (e[7]) check("selTarget", selTarget, e[2:0]);
    if (e[7]) check("selOffset", selOffset, c[24:3]);
    @(posedge core_clk);
    #1 if (c[1]) check("sprDone", sprDone, e[7] && e[2:0] == `TGT_SPR);
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard, well above the ~490 cycles of the sequence
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  // faults first, then corners, then random bases and addresses
  initial begin
    void'($urandom(32'h17d2));
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 96; i++) begin
      @(posedge core_clk);
      lc = 3'($urandom);
      off = i < 16 ? (i[3] ? 22'h3FFFFC : 22'h3F7000) : i < 48 ? corner[i%8] : 22'($urandom);
      hi = i < 64 ? {7'h00, lc} : 10'($urandom);
      fl = i < 16 ? {1'b1, i[1], i[2]} : 3'($urandom);
      loc <= lc;
      dataRelocationBit <= i < 16 ? i[0] : 1'($urandom);
      calramWriteProtect <= i < 16 ? 8'hFF : 8'($urandom);
      access({hi, off, fl});
    end
    final_report();
  end
endmodule // test_internal_memory_map_decode
